// >>> rtl/can_mailbox_status_data.sv
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module can_mailbox_status_data
  import mbox_pkg::*;
#(
  parameter int TS_WIDTH = 16
)(
  input  wire  logic                mclk,
  input  wire  logic                sys_rst,
  input  wire  logic [3:0]          address,
  input  wire  logic                read,
  input  wire  logic                write,
  input  wire  logic [31:0]         writedata,
  input  wire  logic [3:0]          byteenable,
  output logic [31:0]               readdata,
  output logic                      waitrequest,
  input  wire  logic                mode_write,
  input  wire  logic [2:0]          object_type_field,
  input  wire  logic [TS_WIDTH-1:0] timestamp,
  input  wire  logic                core_rx_valid,
  input  wire  logic                core_rx_remote,
  input  wire  logic [3:0]          core_rx_dlc,
  input  wire  logic                core_rx_byte_valid,
  input  wire  logic [7:0]          core_rx_byte,
  input  wire  logic [2:0]          core_rx_byte_index,
  input  wire  logic                core_tx_done,
  input  wire  logic                core_tx_aborted,
  input  wire  logic                core_remote_seen,
  input  wire  logic [2:0]          core_tx_byte_index,
  output logic [7:0]                core_tx_byte,
  output logic                      core_tx_request,
  output logic                      core_tx_remote,
  output logic [3:0]                core_tx_dlc,
  output logic                      core_rx_enable,
  output logic                      mailbox_irq
);
  initial
  begin
    if (TS_WIDTH < 1 || TS_WIDTH > 16)
      $error("timestamp width must be 1 to 16");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_ACK  = 3'b100
  } bus_state_t;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  bus_state_t        state_reg;
  bus_state_t        state_next;
  logic [2:0]        obj_reg;
  logic              ready_reg;
  logic              abort_reg;
  logic              ignored_reg;
  logic              remote_reg;
  logic [3:0]        dlc_reg;
  logic [15:0]       stamp_reg;
  logic [31:0]       data_low_reg;
  logic [31:0]       data_high_reg;
  logic [31:0]       readdata_reg;
  logic              pending_reg;
  logic              remote_req_reg;

  wire fetch      = (state_reg == ST_WAIT);
  wire take       = (state_reg == ST_ACK);
  wire wr_take    = take & write;
  wire rd_fetch   = fetch & read;
  wire hit_status = (address == OFS_STATUS);
  wire hit_low    = (address == OFS_DATA_LOW);
  wire hit_high   = (address == OFS_DATA_HIGH);
  wire hit_ctrl   = (address == OFS_CONTROL);
  wire wr_ctrl    = wr_take & hit_ctrl;
  wire cmd_xfer   = wr_ctrl & byteenable[2] & writedata[XFER_CMD_BIT];
  wire cmd_abort  = wr_ctrl & byteenable[2] & writedata[ABORT_REQ_BIT];
  wire cmd_clear  = cmd_xfer | cmd_abort;
  wire rd_status  = rd_fetch & hit_status;
  wire wr_low     = wr_take & hit_low & ready_reg;
  wire wr_high    = wr_take & hit_high & ready_reg;

  wire is_rx   = (obj_reg == OBJ_RECEIVE);
  wire is_ovwr = (obj_reg == OBJ_RX_OVWR);
  wire is_tx   = (obj_reg == OBJ_TRANSMIT);
  wire is_cons = (obj_reg == OBJ_CONSUMER);
  wire is_prod = (obj_reg == OBJ_PRODUCER);
  wire has_abort = is_tx | is_cons | is_prod;

  wire rx_first   = core_rx_valid & ~ready_reg & (is_rx | is_cons);
  wire rx_capture = rx_first | (core_rx_valid & is_ovwr);
  wire rx_ready   = core_rx_valid & (is_rx | is_ovwr | is_cons);
  wire tx_ready   = core_tx_done & (is_tx | is_prod);
  wire abort_set  = core_tx_aborted & has_abort;
  wire ign_set    = (core_rx_valid & ready_reg & (is_rx | is_cons))
                  | (core_rx_valid & ready_reg & is_ovwr)
                  | (core_remote_seen & is_prod & ~pending_reg);
  wire byte_cap   = core_rx_byte_valid & ~ready_reg & (is_rx | is_ovwr
                  | is_cons) | core_rx_byte_valid & is_ovwr;
  wire type_rdy1  = (object_type_field == OBJ_TRANSMIT)
                  | (object_type_field == OBJ_PRODUCER);

  wire [31:0] status_word = {7'h00, ignored_reg, ready_reg, abort_reg, 1'b0,
                             remote_reg, dlc_reg, stamp_reg};
  wire [31:0] lock_low    = ready_reg ? data_low_reg : UNMAPPED_READ;
  wire [31:0] lock_high   = ready_reg ? data_high_reg : UNMAPPED_READ;
  wire [31:0] read_mux    = hit_status ? status_word
                          : hit_low    ? lock_low
                          : hit_high   ? lock_high
                          : UNMAPPED_READ;
  wire [63:0] data_all    = {data_high_reg, data_low_reg};

  // bus handshake: idle, wait state, answer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (read | write)
          state_next = ST_WAIT;
      end
      ST_WAIT:
      begin
        state_next = ST_ACK;
      end
      ST_ACK:
      begin
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  assign waitrequest     = (state_reg != ST_ACK);
  assign readdata        = readdata_reg;
  assign core_tx_byte    = data_all[core_tx_byte_index*8 +: 8];
  assign core_tx_request = pending_reg & (is_tx | is_prod | is_cons);
  assign core_tx_remote  = remote_req_reg | is_cons;
  assign core_tx_dlc     = dlc_reg;
  assign core_rx_enable  = ~ready_reg & (is_rx | is_cons) | is_ovwr;
  assign mailbox_irq     = ready_reg | abort_reg;

  // bus state
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // read data captured in the wait state, stands at the answer edge
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      readdata_reg <= 32'h0000_0000;
    else if (rd_fetch)
      readdata_reg <= read_mux;
  end

  // object type
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      obj_reg <= OBJ_DISABLED;
    else if (mode_write)
      obj_reg <= object_type_field;
  end

  // ready flag: hardware set wins over command clear
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      ready_reg <= 1'b0;
    else if (mode_write)
      ready_reg <= type_rdy1;
    else if (rx_ready | tx_ready)
      ready_reg <= 1'b1;
    else if (cmd_clear)
      ready_reg <= 1'b0;
  end

  // abort flag: hardware set wins over command clear
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      abort_reg <= 1'b0;
    else if (mode_write)
      abort_reg <= 1'b0;
    else if (abort_set)
      abort_reg <= 1'b1;
    else if (cmd_clear)
      abort_reg <= 1'b0;
  end

  // ignored flag: set wins over status read
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      ignored_reg <= 1'b0;
    else if (ign_set)
      ignored_reg <= 1'b1;
    else if (rd_status)
      ignored_reg <= 1'b0;
  end

  // transfer pending until sent, aborted or retyped
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      pending_reg <= 1'b0;
    else if (cmd_xfer)
      pending_reg <= 1'b1;
    else if (tx_ready | abort_set | cmd_abort | mode_write)
      pending_reg <= 1'b0;
  end

  // remote request from the control register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      remote_req_reg <= 1'b0;
    else if (wr_ctrl & byteenable[2])
      remote_req_reg <= writedata[RTR_REQ_BIT];
  end

  // remote bit of the captured frame
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      remote_reg <= 1'b0;
    else if (rx_capture)
      remote_reg <= core_rx_remote;
  end

  // length code: software write, else captured frame
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      dlc_reg <= 4'h0;
    else if (wr_ctrl & byteenable[2])
      dlc_reg <= writedata[DLC_LSB +: 4];
    else if (rx_capture)
      dlc_reg <= core_rx_dlc;
  end

  // timestamp of the last captured frame or of the last send in transmit or producer mode
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      stamp_reg <= 16'h0000;
    else if (rx_capture | tx_ready)
      stamp_reg <= 16'(timestamp);
  end

  // low data word: bus bytes 0 to 3, software only while ready
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      data_low_reg <= 32'h0000_0000;
    else if (byte_cap)
    begin
      if (!core_rx_byte_index[2])
        data_low_reg[core_rx_byte_index[1:0]*8 +: 8] <= core_rx_byte;
    end
    else if (wr_low)
      data_low_reg <= merge_bytes(data_low_reg, writedata, byteenable);
  end

  // high data word: bus bytes 4 to 7, software only while ready
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      data_high_reg <= 32'h0000_0000;
    else if (byte_cap)
    begin
      if (core_rx_byte_index[2])
        data_high_reg[core_rx_byte_index[1:0]*8 +: 8] <= core_rx_byte;
    end
    else if (wr_high)
      data_high_reg <= merge_bytes(data_high_reg, writedata, byteenable);
  end

endmodule // can_mailbox_status_data
`default_nettype wire

// >>> rtl/mbox_pkg.sv
`default_nettype none
package mbox_pkg;
  localparam logic [3:0] OFS_STATUS    = 4'h0;
  localparam logic [3:0] OFS_DATA_LOW  = 4'h4;
  localparam logic [3:0] OFS_DATA_HIGH = 4'h8;
  localparam logic [3:0] OFS_CONTROL   = 4'hC;
  localparam logic [3:0] OFS_MODE      = 4'h0;
  localparam int TIMESTAMP_LSB = 0;
  localparam int DLC_LSB       = 16;
  localparam int REMOTE_BIT    = 20;
  localparam int ABORT_BIT     = 22;
  localparam int READY_BIT     = 23;
  localparam int IGNORED_BIT   = 24;
  localparam int XFER_CMD_BIT  = 23;
  localparam int ABORT_REQ_BIT = 22;
  localparam int RTR_REQ_BIT   = 20;
  localparam int OBJ_TYPE_LSB  = 24;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  localparam logic [2:0] OBJ_DISABLED  = 3'h0;
  localparam logic [2:0] OBJ_RECEIVE   = 3'h1;
  localparam logic [2:0] OBJ_RX_OVWR   = 3'h2;
  localparam logic [2:0] OBJ_TRANSMIT  = 3'h3;
  localparam logic [2:0] OBJ_CONSUMER  = 3'h4;
  localparam logic [2:0] OBJ_PRODUCER  = 3'h5;
endpackage
`default_nettype wire

// >>> tb/can_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module can_core_model (
  input  wire logic       mclk,
  output logic            core_rx_valid = 1'b0,
  output logic            core_rx_byte_valid = 1'b0,
  output logic [7:0]      core_rx_byte = 8'h00,
  output logic [2:0]      core_rx_byte_index = 3'h0,
  output logic            core_tx_done = 1'b0,
  output logic            core_tx_aborted = 1'b0,
  output logic [2:0]      core_tx_byte_index = 3'h0,
  input  wire logic [7:0] core_tx_byte
);
  task send(input logic [63:0] v);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      core_rx_byte_valid <= 1'b1;
      core_rx_byte_index <= 3'(i);
      core_rx_byte <= v[8*i+:8];
    end
    @(posedge mclk);
    core_rx_byte_valid <= 1'b0;
    core_rx_byte <= ~v[63:56];
    core_rx_valid <= 1'b1;
    @(posedge mclk);
    core_rx_valid <= 1'b0;
  endtask
  task ev(input logic [1:0] m);
    @(posedge mclk);
    {core_tx_done, core_tx_aborted} <= m;
    @(posedge mclk);
    {core_tx_done, core_tx_aborted} <= 2'h0;
  endtask
  task fetch(output logic [63:0] v);
    for (int i = 0; i < 9; i++)
    begin
      @(posedge mclk);
      if (i > 0) v[8*i-8+:8] = core_tx_byte;
      core_tx_byte_index <= 3'(i);
    end
  endtask
endmodule // can_core_model
`default_nettype wire

// >>> tb/can_mailbox_status_data_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module can_mailbox_status_data_asserts
  import mbox_pkg::*;
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic        waitrequest,
  input wire logic        mode_write,
  input wire logic [2:0]  object_type_field,
  input wire logic        core_tx_done,
  input wire logic        core_tx_aborted,
  input wire logic        mailbox_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire hw_ev = core_tx_done || core_tx_aborted;
  wire clr = write && !waitrequest && address == OFS_CONTROL
             && (writedata[23] || writedata[22]);
  a_wait_two: assert property ($rose(read || write) |->
    waitrequest ##1 waitrequest ##1 !waitrequest) else $error("bus late");
  a_idle_wait: assert property (!read && !write |-> waitrequest)
    else $error("idle answer");
  a_abort_irq: assert property (core_tx_aborted |-> ##[1:2] mailbox_irq)
    else $error("abort irq");
  a_sent_irq: assert property (core_tx_done |-> ##[1:2] mailbox_irq)
    else $error("sent irq");
  a_ctl_clear: assert property (clr && !hw_ev |-> ##[1:2] !mailbox_irq)
    else $error("no clear");
  a_tx_select: assert property (mode_write &&
    object_type_field == OBJ_TRANSMIT |-> ##[1:2] mailbox_irq) else $error("tx sel");
  a_rx_select: assert property (mode_write && !hw_ev &&
    object_type_field == OBJ_RECEIVE |-> ##[1:2] !mailbox_irq) else $error("rx sel");
  a_irq_hold: assert property (mailbox_irq && !write && !$past(write)
    && !mode_write && !$past(mode_write) |=> mailbox_irq) else $error("irq drop");
endmodule // can_mailbox_status_data_asserts
bind can_mailbox_status_data can_mailbox_status_data_asserts u_chk (
  .mclk, .sys_rst, .address, .read, .write, .writedata, .waitrequest,
  .mode_write, .object_type_field, .core_tx_done, .core_tx_aborted,
  .mailbox_irq);
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mbox_pkg::*;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic        mode_write = 1'b0;
  logic [2:0]  object_type_field = 3'h0;
  logic [3:0]  byteenable = 4'hF;
  logic [15:0] timestamp = 16'h0;
  logic        core_remote_seen = 1'b0;
  logic [31:0] readdata, q;
  logic        waitrequest, mailbox_irq, core_tx_request;
  logic        core_rx_valid, core_rx_byte_valid, core_tx_done, core_tx_aborted;
  logic [7:0]  core_rx_byte, core_tx_byte;
  logic [2:0]  core_rx_byte_index, core_tx_byte_index;
  logic [3:0]  core_tx_dlc;
  logic [63:0] d;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  always #10 mclk = ~mclk;
  can_mailbox_status_data DUT (.mclk, .sys_rst, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .mode_write,
    .object_type_field, .timestamp, .core_rx_valid,
    .core_rx_remote(1'b0), .core_rx_dlc(4'h8), .core_rx_byte_valid,
    .core_rx_byte, .core_rx_byte_index, .core_tx_done, .core_tx_aborted,
    .core_remote_seen, .core_tx_byte_index, .core_tx_byte,
    .core_tx_request, .core_tx_remote(), .core_tx_dlc,
    .core_rx_enable(), .mailbox_irq);
  can_core_model core (.mclk, .core_rx_valid, .core_rx_byte_valid,
    .core_rx_byte, .core_rx_byte_index, .core_tx_done, .core_tx_aborted,
    .core_tx_byte_index, .core_tx_byte);
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    @(posedge mclk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= wd;
    @(posedge mclk);
    while (waitrequest !== 1'b0) @(posedge mclk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task st(input string nm, input logic [31:0] e);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(nm, q & 32'h01C0_0000, e);
  endtask
  task irq_is(input logic e);
    repeat (2) @(negedge mclk);
    chk("irq", {31'h0, mailbox_irq}, {31'h0, e});
  endtask
  task mode(input logic [2:0] t);
    @(posedge mclk);
    mode_write <= 1'b1;
    object_type_field <= t;
    @(posedge mclk);
    mode_write <= 1'b0;
  endtask
  task t_reset;
    bus(1'b0, 4'h1, 32'h0);
    chk("unmapped", q, UNMAPPED_READ);
    st("status", 32'h0);
    irq_is(1'b0);
    $display("reset test done");
  endtask
  task t_tx;
    mode(OBJ_TRANSMIT);
    st("tx ready", 32'h0080_0000);
    bus(1'b1, OFS_DATA_LOW, 32'h4433_2211);
    bus(1'b1, OFS_DATA_HIGH, 32'h8877_6655);
    bus(1'b1, OFS_CONTROL, 32'h0088_0000);
    st("tx start", 32'h0);
    irq_is(1'b0);
    chk("tx req", {31'h0, core_tx_request}, 32'h1);
    chk("tx dlc", {28'h0, core_tx_dlc}, 32'h8);
    bus(1'b0, OFS_DATA_LOW, 32'h0);
    chk("locked", q, 32'h0);
    core.fetch(d);
    chk("tx low", d[31:0], 32'h4433_2211);
    chk("tx high", d[63:32], 32'h8877_6655);
    core.ev(2'b10);
    st("tx sent", 32'h0080_0000);
    bus(1'b1, OFS_CONTROL, 32'h0080_0000);
    core.ev(2'b01);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("abort", q & 32'h0040_0000, 32'h0040_0000);
    irq_is(1'b1);
    bus(1'b1, OFS_CONTROL, 32'h0040_0000);
    st("abort clr", 32'h0);
    irq_is(1'b0);
    $display("transmit test done");
  endtask
  task t_rx(input logic [2:0] t, input logic [63:0] e);
    mode(OBJ_TRANSMIT);
    mode(t);
    st("rx select", 32'h0);
    bus(1'b1, OFS_CONTROL, 32'h0080_0000);
    bus(1'b0, OFS_DATA_HIGH, 32'h0);
    chk("rx locked", q, 32'h0);
    core.send(64'h1122_3344_5566_7788);
    st("rx first", 32'h0080_0000);
    irq_is(1'b1);
    core.send(64'h99AA_BBCC_DDEE_FF00);
    st("rx second", 32'h0180_0000);
    st("mi clear", 32'h0080_0000);
    bus(1'b0, OFS_DATA_LOW, 32'h0);
    chk("rx low", q, e[31:0]);
    bus(1'b0, OFS_DATA_HIGH, 32'h0);
    chk("rx high", q, e[63:32]);
    $display("receive test done");
  endtask
  task t_prod;
    mode(OBJ_PRODUCER);
    @(posedge mclk);
    core_remote_seen <= 1'b1;
    timestamp <= 16'h1234;
    @(posedge mclk);
    core_remote_seen <= 1'b0;
    st("prod ign", 32'h0180_0000);
    core.ev(2'b10);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("stamp", {16'h0, q[15:0]}, 32'h0000_1234);
    byteenable <= 4'h1;
    bus(1'b1, OFS_DATA_LOW, 32'hFFFF_FFFF);
    byteenable <= 4'hF;
    bus(1'b0, OFS_DATA_LOW, 32'h0);
    chk("lane", q, 32'hDDEE_FFFF);
    $display("producer test done");
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      wrap_up;
    end
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset;
    t_tx;
    t_rx(OBJ_RECEIVE, 64'h1122_3344_5566_7788);
    t_rx(OBJ_RX_OVWR, 64'h99AA_BBCC_DDEE_FF00);
    t_prod;
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
